// File: sah_ctrl.sv
// Purpose: successive-approximation control and host side of an 8-bit adc
// Assumes: conv clock, start, select and strobes come from pins
// Notes:   three-state data shown as value plus per-line output enable
//
// Notes on behaviour
// - result on eight three-state lines, line 0 lsb, line 7 msb.
// - done_n high while converting, low when result valid.
// - done_n is always driven, never high impedance.
// - start low with clock and select low clears approximation register.
// - conversion begins when start returns high after clearing.
// - start or read accepted only while select is low.
// - select high floats data lines and blocks clearing; start release and clock still run a conversion.
// - data lines driven only while read strobe is low.
// - status select low puts done_n on msb, floats seven lines.
// - code select low gives two's complement, high straight binary.
// - done_n rises on start, select and clock all low.
// - done_n falls after the rising edge ending the last step.
// - enabled data lines follow register after each rising clock edge.
// - conversion lasts at least nine clocks from start release.
// - each conversion starts with msb trial set, then tests bits.
`timescale 1ns/10ps
module sah_ctrl #(
	parameter int WIDTH = sah_pkg::RES_BITS
) (
	input  wire logic             sys_clk_in,
	input  wire logic             nrst_in,
	input  wire logic             conv_clk_in,
	input  wire logic             start_n_in,
	input  wire logic             cs_n_in,
	input  wire logic             rd_n_in,
	input  wire logic             data_or_status_sel_in,
	input  wire logic             twos_comp_n_sel_in,
	input  wire logic             cmp_ge_in,
	output logic [WIDTH-1:0]      dac_code_out,
	output logic                  conv_done_n_out,
	output logic [WIDTH-1:0]      result_bus_out,
	output logic [WIDTH-1:0]      result_bus_oe_out
);

	typedef enum logic [1:0] {SAH_IDLE, SAH_CLEAR, SAH_CONV, SAH_DONE}
		sah_state_e;

	// three-stage synchronisers for every pin input
	logic [2:0] clk_s, st_s, cs_s, rd_s, ds_s, cd_s, cmp_s;
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			clk_s <= 3'h0;
			st_s  <= 3'h7;
			cs_s  <= 3'h7;
			rd_s  <= 3'h7;
			ds_s  <= 3'h7;
			cd_s  <= 3'h7;
			cmp_s <= 3'h0;
		end else begin
			clk_s <= {clk_s[1:0], conv_clk_in};
			st_s  <= {st_s[1:0], start_n_in};
			cs_s  <= {cs_s[1:0], cs_n_in};
			rd_s  <= {rd_s[1:0], rd_n_in};
			ds_s  <= {ds_s[1:0], data_or_status_sel_in};
			cd_s  <= {cd_s[1:0], twos_comp_n_sel_in};
			cmp_s <= {cmp_s[1:0], cmp_ge_in};
		end
	end

	// filtered levels: change only when stages two and three agree
	logic clk_f, st_f, cs_f, rd_f, ds_f, cd_f, cmp_f;
	function automatic logic agree(input logic [2:0] s, input logic prev);
		agree = (s[1] == s[2]) ? s[2] : prev;
	endfunction : agree

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			clk_f <= 1'b0;
			st_f  <= 1'b1;
			cs_f  <= 1'b1;
			rd_f  <= 1'b1;
			ds_f  <= 1'b1;
			cd_f  <= 1'b1;
			cmp_f <= 1'b0;
		end else begin
			clk_f <= agree(clk_s, clk_f);
			st_f  <= agree(st_s, st_f);
			cs_f  <= agree(cs_s, cs_f);
			rd_f  <= agree(rd_s, rd_f);
			ds_f  <= agree(ds_s, ds_f);
			cd_f  <= agree(cd_s, cd_f);
			cmp_f <= agree(cmp_s, cmp_f);
		end
	end

	// conversion clock rising edge as a one-cycle enable
	logic clk_prev_r;
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			clk_prev_r <= 1'b0;
		else
			clk_prev_r <= clk_f;
	end
	logic step_en;
	assign step_en = clk_f & ~clk_prev_r;

	// clearing condition: all three low; select high ignores start
	logic clear_cond;
	assign clear_cond = ~st_f & ~cs_f & ~clk_f;

	sah_state_e     state_r;
	logic [WIDTH-1:0] sar_r;    // approx_register
	logic [WIDTH-1:0] trial_r;  // one-hot bit under test
	logic [3:0]     step_r;

	// state sequencing; clearing wins over everything else
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_r <= SAH_IDLE;
		end else if (clear_cond) begin
			state_r <= SAH_CLEAR;
		end else begin
			case (state_r)
				SAH_CLEAR:
					if (st_f && step_en)
						state_r <= SAH_CONV;
				SAH_CONV:
					if (step_en && trial_r[0])
						state_r <= SAH_DONE;
				default: state_r <= state_r; // idle/done hold
			endcase
		end
	end

	// approximation register: msb trial first, one bit per edge
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sar_r   <= sah_pkg::RESULT_RST;
			trial_r <= '0;
			step_r  <= 4'h0;
		end else if (clear_cond) begin
			sar_r   <= '0;
			trial_r <= '0;
			step_r  <= 4'h0;
		end else if (step_en && state_r == SAH_CLEAR && st_f) begin
			sar_r   <= sah_pkg::TRIAL_MSB;
			trial_r <= sah_pkg::TRIAL_MSB;
			step_r  <= 4'h1;
		end else if (step_en && state_r == SAH_CONV) begin
			// keep bit when input at or above trial level
			sar_r <= (sar_r & ~(cmp_f ? '0 : trial_r)) | (trial_r >> 1);
			trial_r <= trial_r >> 1;
			step_r  <= step_r + 4'h1;
		end
	end

	// completion flag: high from clearing until the final edge
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			conv_done_n_out <= 1'b0;
		else
			conv_done_n_out <= (state_r == SAH_CLEAR ||
				state_r == SAH_CONV || clear_cond) &&
				!(state_r == SAH_CONV && step_en && trial_r[0]);
	end // always driven, no enable

	assign dac_code_out = sar_r;

	// output formatting: two's complement flips the msb only
	logic [WIDTH-1:0] fmt;
	assign fmt = cd_f ? sar_r : {~sar_r[WIDTH-1], sar_r[WIDTH-2:0]};

	// data and enables registered; bus tracks register live
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			result_bus_out    <= '0;
			result_bus_oe_out <= '0;
		end else if (cs_f || rd_f) begin
			result_bus_out    <= '0;
			result_bus_oe_out <= '0;
		end else if (!ds_f) begin
			result_bus_out    <= {conv_done_n_out, {(WIDTH-1){1'b0}}};
			result_bus_oe_out <= {1'b1, {(WIDTH-1){1'b0}}};
		end else begin
			result_bus_out    <= fmt;
			result_bus_oe_out <= '1;
		end
	end

	// conversion length counter for the checks below
	int unsigned conv_cnt;
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			conv_cnt <= 0;
		else if (state_r != SAH_CONV)
			conv_cnt <= 0;
		else if (step_en)
			conv_cnt <= conv_cnt + 1;
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);

	sequence s_clear; clear_cond; endsequence
	sequence s_last; state_r == SAH_CONV && step_en && trial_r[0]; endsequence

	a_clear_raises_done: assert property (s_clear |=> conv_done_n_out)
		else $error("done_n not raised on clear");
	a_last_drops_done: assert property (s_last ##0 !clear_cond
		|=> !conv_done_n_out)
		else $error("done_n not dropped after last step");
	a_clear_zero_sar: assert property (s_clear |=> sar_r == '0)
		else $error("register not cleared");
	a_done_steps: assert property (s_last |-> step_r == sah_pkg::STEP_LAST &&
		conv_cnt == 7)
		else $error("conversion length wrong");
	a_cs_floats: assert property (cs_f |=> result_bus_oe_out == '0)
		else $error("bus driven while deselected");
	a_rd_floats: assert property (rd_f |=> result_bus_oe_out == '0)
		else $error("bus driven with read high");
	a_status_msb: assert property (!cs_f && !rd_f && !ds_f
		|=> result_bus_oe_out == 8'h80)
		else $error("status mode enables wrong");
	a_hold_done: assert property (state_r == SAH_DONE && !clear_cond
		|=> $stable(sar_r))
		else $error("result changed after completion");
	a_msb_first: assert property (state_r == SAH_CLEAR && st_f && step_en
		&& !clear_cond |=> sar_r == sah_pkg::TRIAL_MSB)
		else $error("conversion did not start at msb");
	a_twos_fmt: assert property (!cs_f && !rd_f && ds_f && !cd_f
		|=> result_bus_out[7] != sar_r[7] || $changed(sar_r))
		else $error("two's complement msb not inverted");

	// per-step sequences; clearing always overrides a step
	sequence s_step;
		state_r == SAH_CONV && step_en && !clear_cond;
	endsequence
	sequence s_load;
		state_r == SAH_CLEAR && st_f && step_en && !clear_cond;
	endsequence

	// completion flag: high while busy, low and held once done
	property p_busy_high;
		state_r == SAH_CONV && !(step_en && trial_r[0]) |=> conv_done_n_out;
	endproperty
	a_busy_high: assert property (p_busy_high)
		else $error("done_n low during conversion");
	property p_done_low;
		state_r == SAH_DONE && !clear_cond |=> !conv_done_n_out;
	endproperty
	a_done_low: assert property (p_done_low)
		else $error("done_n left low state after completion");

	// flag stays driven whatever the select does
	property p_flag_no_cs;
		cs_f && state_r == SAH_CLEAR |=> conv_done_n_out;
	endproperty
	a_flag_no_cs: assert property (p_flag_no_cs)
		else $error("done_n dropped while deselected");

	// start release and the first clock rise open a conversion
	property p_start_conv;
		s_load |=> state_r == SAH_CONV;
	endproperty
	a_start_conv: assert property (p_start_conv)
		else $error("conversion did not start");
	property p_hold_clear;
		state_r == SAH_CLEAR && !st_f |=> state_r == SAH_CLEAR;
	endproperty
	a_hold_clear: assert property (p_hold_clear)
		else $error("conversion started with start low");

	// deselected: a finished result is neither cleared nor restarted
	property p_cs_ignored;
		cs_f && state_r == SAH_DONE |=> state_r == SAH_DONE && $stable(sar_r);
	endproperty
	a_cs_ignored: assert property (p_cs_ignored)
		else $error("deselected block reacted to controls");

	// read path: lines show the register one cycle after the filtered levels
	property p_data_lines;
		!cs_f && !rd_f && ds_f && cd_f |=>
			result_bus_oe_out == '1 && result_bus_out == $past(sar_r);
	endproperty
	a_data_lines: assert property (p_data_lines)
		else $error("data lines not showing the register");
	property p_status_line;
		!cs_f && !rd_f && !ds_f |=>
			result_bus_out == {$past(conv_done_n_out), {(WIDTH-1){1'b0}}};
	endproperty
	a_status_line: assert property (p_status_line)
		else $error("status line not showing done_n");

	// bit decisions: keep on comparator high, clear otherwise
	property p_keep_bit;
		s_step ##0 cmp_f |=> (sar_r & $past(trial_r)) == $past(trial_r);
	endproperty
	a_keep_bit: assert property (p_keep_bit)
		else $error("bit dropped with comparator high");
	property p_drop_bit;
		s_step ##0 !cmp_f |=> (sar_r & $past(trial_r)) == '0;
	endproperty
	a_drop_bit: assert property (p_drop_bit)
		else $error("bit kept with comparator low");
	property p_next_trial;
		s_step |=> (trial_r == ($past(trial_r) >> 1)) &&
			((sar_r & trial_r) == trial_r);
	endproperty
	a_next_trial: assert property (p_next_trial)
		else $error("next trial bit not set");

	// register moves only on a clock step or a clear
	property p_step_only;
		!step_en && !clear_cond |=> $stable(sar_r);
	endproperty
	a_step_only: assert property (p_step_only)
		else $error("register moved without a clock rise");

endmodule : sah_ctrl

// File: sah_pkg.sv
// Purpose: constants for the sar adc host interface control block
// Assumes: 8-bit result, 100 MHz system clock
// Notes:   conversion clock arrives on a pin and is synchronised
package sah_pkg;
	localparam int          RES_BITS  = 8;
	localparam int          SYNC_LEN  = 3;
	localparam logic [7:0]  RESULT_RST = 8'h00;
	localparam logic [7:0]  TRIAL_MSB  = 8'h80;
	localparam logic [3:0]  STEP_LAST  = 4'h8; // start step plus 7 bit steps
	localparam int          CLK_MAX_KHZ = 5000;
endpackage : sah_pkg

// File: sah_analog_model.sv
// Purpose: comparator stand-in facing the trial code of the block
// Assumes: ideal comparator, input level held for a whole conversion
// Notes:   no settling delay, so every trial resolves at once
`timescale 1ns/10ps
module sah_analog_model (
	input  wire logic [7:0] dac_code_in,
	input  wire logic [7:0] level_in,
	output logic            cmp_ge_out
);
	// input at or above the trial level keeps the bit
	assign cmp_ge_out = (level_in >= dac_code_in);
endmodule : sah_analog_model

// File: sah_ctrl_bench.sv
// Purpose: self-checking bench for the adc control block
// Assumes: conv clock made here at 5 MHz, pins driven at falling edge
// Notes:   expected result equals the held level, bit for bit
`timescale 1ns/10ps
module sah_ctrl_bench;
	logic       sys_clk_in, nrst_in, conv_clk_in, start_n_in, cs_n_in;
	logic       rd_n_in, data_or_status_sel_in, twos_comp_n_sel_in;
	logic       cmp_ge, done_n;
	logic [7:0] level, dac_code, bus, oe;
	int         errors, n_tests;

	sah_ctrl i_sah_ctrl (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.conv_clk_in(conv_clk_in), .start_n_in(start_n_in),
		.cs_n_in(cs_n_in), .rd_n_in(rd_n_in),
		.data_or_status_sel_in(data_or_status_sel_in),
		.twos_comp_n_sel_in(twos_comp_n_sel_in), .cmp_ge_in(cmp_ge),
		.dac_code_out(dac_code), .conv_done_n_out(done_n),
		.result_bus_out(bus), .result_bus_oe_out(oe));
	sah_analog_model i_sah_analog_model (.dac_code_in(dac_code),
		.level_in(level), .cmp_ge_out(cmp_ge));

	// system clock, 10 ns period
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	task wait_n(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask : wait_n

	task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// 100 ns per phase keeps the conv clock at its 5 MHz ceiling
	task tick;
		conv_clk_in = 1'b1;
		wait_n(10);
		conv_clk_in = 1'b0;
		wait_n(10);
	endtask : tick

	// read with enough slack for the pin synchronisers
	task rd(input logic ds, input logic sel, input logic [7:0] eb, ev);
		data_or_status_sel_in = ds;
		twos_comp_n_sel_in = sel;
		rd_n_in = 1'b0;
		wait_n(6);
		chk("oe", ev, oe);
		chk("bus", eb, bus);
		rd_n_in = 1'b1;
		wait_n(6);
		chk("oe idle", 8'h00, oe);
	endtask : rd

	task convert(input logic [7:0] v);
		level = v;
		cs_n_in = 1'b0;
		start_n_in = 1'b0;
		wait_n(8);
		chk("done_n", 8'h01, {7'h00, done_n});
		start_n_in = 1'b1;
		wait_n(8);
		rd(1'b0, 1'b1, 8'h80, 8'h80);
		rd_n_in = 1'b0;
		data_or_status_sel_in = 1'b1;
		tick();
		chk("dac", 8'h80, dac_code);
		chk("bus", 8'h80, bus);
		repeat (7) tick();
		chk("done_n", 8'h01, {7'h00, done_n});
		tick();
		chk("done_n", 8'h00, {7'h00, done_n});
		chk("dac", v, dac_code);
		rd_n_in = 1'b1;
		wait_n(6);
	endtask : convert

	task end_of_test;
		$display("errors %0d comparisons %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	// watchdog well beyond the roughly 800 cycles the tests need
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		errors++;
		end_of_test();
	end

	initial begin
		{nrst_in, conv_clk_in, cs_n_in, rd_n_in} = 4'h3;
		{start_n_in, data_or_status_sel_in, twos_comp_n_sel_in} = 3'h7;
		{errors, n_tests, level} = '0;
		wait_n(3);
		nrst_in = 1'b1;
		wait_n(6);
		convert(8'hA5);
		rd(1'b1, 1'b1, 8'hA5, 8'hFF);
		rd(1'b1, 1'b0, 8'h25, 8'hFF);
		rd(1'b0, 1'b1, 8'h00, 8'h80);
		repeat (3) tick();
		rd(1'b1, 1'b1, 8'hA5, 8'hFF);
		// deselected: no clear, no read
		cs_n_in = 1'b1;
		rd_n_in = 1'b0;
		start_n_in = 1'b0;
		wait_n(8);
		chk("oe", 8'h00, oe);
		chk("done_n", 8'h00, {7'h00, done_n});
		start_n_in = 1'b1;
		rd_n_in = 1'b1;
		tick();
		chk("dac", 8'hA5, dac_code);
		convert(8'h00);
		rd(1'b1, 1'b0, 8'h80, 8'hFF);
		convert(8'hFF);
		rd(1'b1, 1'b0, 8'h7F, 8'hFF);
		end_of_test();
	end
endmodule : sah_ctrl_bench
